// ==== hw/ulp_list_pointers.sv ====
// Overview of operation
// - The periodic current pointer holds the periodic descriptor address in bits 31 to 4, read-only to software and written by the controller.
// - The periodic current pointer is loaded with the head of this frame's periodic list, then addresses the periodic descriptor now processed.
// - After each periodic descriptor is finished the controller writes a new periodic pointer.
// - The control head holds the first control descriptor address in bits 31 to 4, writable by software and also written by the controller at initialisation.
// - Walking the control list starts at the address held in the control head.
// - At controller initialisation the control head is loaded from the communication area in memory.
// - The control current pointer holds the descriptor now served in bits 31 to 4; both may read it, software may write it only while enable is clear.
// - When a control descriptor is finished the current pointer advances to the next descriptor.
// - Each frame resumes the control list where the previous frame stopped, not at the head.
// - At the end of the control list a set filled flag copies the head into the current pointer and clears the flag, otherwise nothing happens.
// - After reset the control current pointer is zero, which marks the end of the list.
// - The communication area base is 256-byte aligned and comes from the communication area base register.
//
// Design decision made here: the plain strobed port.
module ulp_list_pointers
  import ulp_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire ulp_bus_req_s bus_i,
  output logic [31:0]       rd_data_o,
  input  wire logic         init_start_i,
  output ulp_mem_req_s      mem_o,
  input  wire logic         mem_ack_i,
  input  wire logic [31:0]  mem_rdata_i,
  input  wire logic         ctrl_slot_i,
  output ulp_mem_req_s      ed_o,
  input  wire logic         ed_done_i,
  input  wire logic [31:0]  ed_next_i,
  input  wire logic         per_load_i,
  input  wire logic [31:0]  per_head_i,
  input  wire logic         per_done_i,
  input  wire logic [31:0]  per_next_i,
  output logic [31:0]       per_addr_o,
  output logic              busy_o
);

  ulp_state_s q;
  ulp_state_s next_q;

  assign rd_data_o = q.rd_data;
  assign mem_o     = q.mem;
  assign ed_o      = q.ed;
  assign per_addr_o = {q.per_ptr, 4'h0};
  assign busy_o     = q.ed.req;

  always_comb
  begin
    next_q = q;
    next_q.rd_data = 32'h00000000;

    if (per_load_i)
    begin
      next_q.per_ptr = per_head_i[31:PTR_LSB];
    end
    else if (per_done_i)
    begin
      next_q.per_ptr = per_next_i[31:PTR_LSB];
    end

    // Only one engine action at a time keeps memory traffic ordered.
    unique case (q.st)
      ST_IDLE:
      begin
        if (init_start_i)
        begin
          next_q.st       = ST_INIT;
          next_q.mem.req  = 1'b1;
          next_q.mem.addr = {q.comm_base, 8'h00} + COMM_HEAD_OFS;
        end
        else if (ctrl_slot_i && q.enable)
        begin
          if (q.cur_ptr == PTR_RST)
          begin
            if (q.filled)
            begin
              next_q.cur_ptr = q.head_ptr;
              next_q.filled  = 1'b0;
            end
          end
          else
          begin
            next_q.st      = ST_SERVE;
            next_q.ed.req  = 1'b1;
            next_q.ed.addr = {q.cur_ptr, 4'h0};
          end
        end
      end
      ST_INIT:
      begin
        if (mem_ack_i)
        begin
          next_q.head_ptr = mem_rdata_i[31:PTR_LSB];
          next_q.mem.req  = 1'b0;
          next_q.st       = ST_IDLE;
        end
      end
      ST_SERVE:
      begin
        if (ed_done_i)
        begin
          next_q.cur_ptr = ed_next_i[31:PTR_LSB];
          next_q.ed.req  = 1'b0;
          next_q.st      = ST_IDLE;
        end
      end
      default:
      begin
        next_q.st      = ST_IDLE;
        next_q.mem.req = 1'b0;
        next_q.ed.req  = 1'b0;
      end
    endcase

    // Software writes come last, so a filled set beats the hardware clear.
    if (bus_i.we)
    begin
      unique case (bus_i.addr)
        OFS_CONTROL:
        begin
          next_q.enable = bus_i.wdata[CTRL_ENABLE_BIT];
        end
        OFS_CMD_STATUS:
        begin
          if (bus_i.wdata[CTRL_FILLED_BIT])
          begin
            next_q.filled = 1'b1;
          end
        end
        OFS_COMM_BASE:
        begin
          next_q.comm_base = bus_i.wdata[31:COMM_LSB];
        end
        OFS_CTRL_HEAD:
        begin
          next_q.head_ptr = bus_i.wdata[31:PTR_LSB];
        end
        OFS_CTRL_CUR:
        begin
          if (!q.enable)
          begin
            next_q.cur_ptr = bus_i.wdata[31:PTR_LSB];
          end
        end
        default:
        begin
          next_q.rd_data = 32'h00000000;
        end
      endcase
    end

    if (bus_i.re)
    begin
      unique case (bus_i.addr)
        OFS_CONTROL:
        begin
          next_q.rd_data[CTRL_ENABLE_BIT] = q.enable;
        end
        OFS_CMD_STATUS:
        begin
          next_q.rd_data[CTRL_FILLED_BIT] = q.filled;
        end
        OFS_COMM_BASE:
        begin
          next_q.rd_data = {q.comm_base, 8'h00};
        end
        OFS_PERIOD_CUR:
        begin
          next_q.rd_data = {q.per_ptr, 4'h0};
        end
        OFS_CTRL_HEAD:
        begin
          next_q.rd_data = {q.head_ptr, 4'h0};
        end
        OFS_CTRL_CUR:
        begin
          next_q.rd_data = {q.cur_ptr, 4'h0};
        end
        default:
        begin
          next_q.rd_data = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q.st        <= ST_IDLE;
      q.per_ptr   <= PTR_RST;
      q.head_ptr  <= PTR_RST;
      q.cur_ptr   <= PTR_RST;
      q.comm_base <= COMM_RST;
      q.enable    <= 1'b0;
      q.filled    <= 1'b0;
      q.mem       <= '0;
      q.ed        <= '0;
      q.rd_data   <= 32'h00000000;
    end
    else
    begin
      q <= next_q;
    end
  end

endmodule

// ==== hw/ulp_pkg.sv ====
package ulp_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_CONTROL      = 8'h04;
  localparam logic [7:0] OFS_CMD_STATUS   = 8'h08;
  localparam logic [7:0] OFS_COMM_BASE    = 8'h18;
  localparam logic [7:0] OFS_PERIOD_CUR   = 8'h1c;
  localparam logic [7:0] OFS_CTRL_HEAD    = 8'h20;
  localparam logic [7:0] OFS_CTRL_CUR     = 8'h24;

  // Field positions.
  localparam int unsigned CTRL_ENABLE_BIT = 4;
  localparam int unsigned CTRL_FILLED_BIT = 1;
  localparam int unsigned PTR_LSB         = 4;
  localparam int unsigned COMM_LSB        = 8;

  // Reset values.
  localparam logic [27:0] PTR_RST   = 28'h0000000;
  localparam logic [23:0] COMM_RST  = 24'h000000;

  // Place of the control head entry inside the communication area.
  localparam logic [31:0] COMM_HEAD_OFS = 32'h000000f0;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_INIT  = 3'b010,
    ST_SERVE = 3'b100
  } ulp_state_e;

  typedef struct packed
  {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } ulp_bus_req_s;

  typedef struct packed
  {
    logic        req;
    logic [31:0] addr;
  } ulp_mem_req_s;

  typedef struct packed
  {
    ulp_state_e   st;
    logic [27:0]  per_ptr;
    logic [27:0]  head_ptr;
    logic [27:0]  cur_ptr;
    logic [23:0]  comm_base;
    logic         enable;
    logic         filled;
    ulp_mem_req_s mem;
    ulp_mem_req_s ed;
    logic [31:0]  rd_data;
  } ulp_state_s;

endpackage

// ==== bench/ulp_list_pointers_monitor.sv ====
module ulp_mon
  import ulp_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rstn_i,
  input wire ulp_bus_req_s bus_i,
  input wire logic [31:0]  rd_data_o,
  input wire logic         init_start_i,
  input wire ulp_mem_req_s mem_o,
  input wire ulp_mem_req_s ed_o,
  input wire logic         ed_done_i,
  input wire logic         per_load_i,
  input wire logic [31:0]  per_head_i,
  input wire logic         per_done_i,
  input wire logic [31:0]  per_next_i,
  input wire logic [31:0]  per_addr_o,
  input wire logic         busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_done;
    ed_o.req && ed_done_i;
  endsequence
  property p_rd;
    bus_i.re && bus_i.addr == 8'h1c |=> rd_data_o == $past(per_addr_o);
  endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_pl;
    per_load_i |=> per_addr_o == ($past(per_head_i) & 32'hfffffff0);
  endproperty
  a_pl: assert property (p_pl) else $error("bad load");
  property p_pd;
    per_done_i && !per_load_i
      |=> per_addr_o == ($past(per_next_i) & 32'hfffffff0);
  endproperty
  a_pd: assert property (p_pd) else $error("bad next");
  property p_in;
    init_start_i && !mem_o.req && !busy_o |=> mem_o.req;
  endproperty
  a_in: assert property (p_in) else $error("no fetch");
  property p_ca;
    mem_o.req |-> mem_o.addr[7:0] == 8'hf0;
  endproperty
  a_ca: assert property (p_ca) else $error("bad fetch");
  property p_eh;
    ed_o.req && !ed_done_i |=> ed_o.req && $stable(ed_o.addr);
  endproperty
  a_eh: assert property (p_eh) else $error("req lost");
  property p_ed;
    s_done |=> !ed_o.req;
  endproperty
  a_ed: assert property (p_ed) else $error("req stuck");
  property p_nz;
    ed_o.req |-> ed_o.addr != 0 && ed_o.addr[3:0] == 4'h0;
  endproperty
  a_nz: assert property (p_nz) else $error("bad ed");
endmodule
bind ulp_list_pointers ulp_mon ulp_mon_inst (.clk_i, .rstn_i, .bus_i,
  .rd_data_o, .init_start_i, .mem_o, .ed_o, .ed_done_i, .per_load_i,
  .per_head_i, .per_done_i, .per_next_i, .per_addr_o, .busy_o);

// ==== bench/ulp_far_end.sv ====
module ulp_far_end
  import ulp_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         slow_i,
  input  wire ulp_mem_req_s mem_i,
  input  wire ulp_mem_req_s ed_i,
  output logic              ack_o,
  output logic [31:0]       rdata_o,
  output logic              done_o,
  output logic [31:0]       next_o
);
  logic [2:0] wait_q;
  initial
  begin
    {ack_o, done_o, wait_q, rdata_o, next_o} = '0;
  end
  // Idle data lines toggle so a stale word never passes for a fresh one.
  always @(posedge clk_i)
  begin
    {ack_o, done_o, wait_q} <= '0;
    rdata_o <= ~rdata_o;
    next_o  <= ~next_o;
    if ((mem_i.req || ed_i.req) && !ack_o && !done_o)
    begin
      wait_q <= wait_q + 3'h1;
      if (wait_q >= (slow_i ? 3'h4 : 3'h0))
      begin
        {ack_o, done_o, wait_q} <= {mem_i.req, ed_i.req, 3'h0};
        rdata_o <= 32'h00001238;
        next_o  <= ed_i.addr >= 32'h12b0 ? '0 : ed_i.addr + 32'h45;
      end
    end
  end
endmodule

// ==== bench/ulp_list_pointers_test.sv ====
module ulp_list_pointers_test
  import ulp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_i = 1'b0;
  logic         rstn_i = 1'b0;
  ulp_bus_req_s bus_i = '0;
  logic         init_start_i = 1'b0;
  logic         ctrl_slot_i = 1'b0;
  logic         per_load_i = 1'b0;
  logic         per_done_i = 1'b0;
  logic         slow = 1'b1;
  logic [31:0]  per_head_i = 32'h2005;
  logic [31:0]  per_next_i = 32'h3007;
  logic [31:0]  rd_data_o, mem_rdata_i, ed_next_i, per_addr_o;
  logic         mem_ack_i, ed_done_i, busy_o;
  ulp_mem_req_s mem_o, ed_o;
  int           failures = 0;
  int           checks_done = 0;
  logic [71:0]  rows [5] = '{{8'h20, 32'hffffffff, 32'hfffffff0},
    {8'h24, 32'hffffffff, 32'hfffffff0}, {8'h1c, 32'hffffffff, 32'h0},
    {8'h18, 32'hffffffff, 32'hffffff00}, {8'h50, 32'hffffffff, 32'h0}};
  ulp_list_pointers ulp_list_pointers_inst (.clk_i, .rstn_i, .bus_i,
    .rd_data_o, .init_start_i, .mem_o, .mem_ack_i, .mem_rdata_i,
    .ctrl_slot_i, .ed_o, .ed_done_i, .ed_next_i, .per_load_i, .per_head_i,
    .per_done_i, .per_next_i, .per_addr_o, .busy_o);
  ulp_far_end ulp_far_end_inst (.clk_i, .slow_i(slow), .mem_i(mem_o),
    .ed_i(ed_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i),
    .done_o(ed_done_i), .next_o(ed_next_i));
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(logic w, r, logic [7:0] a, logic [31:0] d, e);
    @(posedge clk_i);
    bus_i <= '{a, d, w, r};
    @(posedge clk_i);
    bus_i <= '0;
    #1 if (r) chk("rd_data_o", e, rd_data_o);
  endtask
  // One strobe vector: a by-reference strobe could not take a nonblocking
  // assignment, and a stuck load would mask every later periodic update.
  task automatic pulse(logic [3:0] m);
    @(posedge clk_i);
    {per_load_i, init_start_i, ctrl_slot_i, per_done_i} <= m;
    @(posedge clk_i);
    {per_load_i, init_start_i, ctrl_slot_i, per_done_i} <= 4'h0;
    #1;
  endtask
  task automatic slot(logic [31:0] e);
    pulse(4'h2);
    chk("ed_o.addr", e, ed_o.req ? ed_o.addr : '0);
    chk("busy_o", {31'h0, e != 32'h0}, {31'h0, busy_o});
    repeat (20) if (busy_o || mem_o.req) @(posedge clk_i);
  endtask
  task automatic rst();
    rstn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 3; i++) xfer(0, 1, 8'h1c + 8'(4 * i), 0, 0);
  endtask
  task automatic finish_test();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst();
    foreach (rows[i])
    begin
      xfer(1, 0, rows[i][71:64], rows[i][63:32], 0);
      xfer(0, 1, rows[i][71:64], 0, rows[i][31:0]);
    end
    xfer(1, 0, 8'h18, 32'h45ab, 0);
    pulse(4'h4);
    chk("mem_o.addr", 32'h45f0, mem_o.req ? mem_o.addr : '0);
    slot(0);
    xfer(0, 1, 8'h20, 0, 32'h1230);
    xfer(1, 0, 8'h24, 0, 0);
    xfer(1, 0, 8'h04, 32'h10, 0);
    xfer(1, 0, 8'h24, 32'h990, 0);
    xfer(0, 1, 8'h24, 0, 0);
    xfer(1, 0, 8'h08, 32'h2, 0);
    slot(0);
    xfer(0, 1, 8'h24, 0, 32'h1230);
    xfer(0, 1, 8'h08, 0, 0);
    slot(32'h1230);
    xfer(0, 1, 8'h24, 0, 32'h1270);
    pulse(4'h9);
    chk("per_addr_o", 32'h2000, per_addr_o);
    pulse(4'h1);
    xfer(0, 1, 8'h1c, 0, 32'h3000);
    slot(32'h1270);
    slow <= 1'b0;
    slot(32'h12b0);
    slot(0);
    xfer(0, 1, 8'h24, 0, 0);
    rst();
    finish_test();
  end
  initial
  begin
    #20000;
    failures++;
    finish_test();
  end
endmodule
